// >>> logic/spcc_pkg.sv
// package of constants for the scan port connect control
package spcc_pkg;
  localparam int unsigned ADDR_W    = 10;
  localparam int unsigned ADDR_BITS = 10;
  localparam logic [9:0]  RESET_ADDR = 10'h000;
  localparam logic [9:0]  DISC_ADDR  = 10'h3FE;
  localparam logic [9:0]  TSYNC_ADDR = 10'h3FF;
  localparam logic [3:0]  CNT_ZERO   = 4'h0;
  localparam logic [3:0]  CNT_ONE    = 4'h1;
  localparam logic [3:0]  CNT_FULL   = 4'hA;
  // acknowledge index at which the output enable drops again
  localparam logic [4:0]  TX_END     = 5'h1C;

  // mirror tap states, gray codes along the main path
  typedef enum logic [3:0] {
    SPCC_TLR  = 4'h0, SPCC_RTI  = 4'h1, SPCC_SDR  = 4'h3, SPCC_CDR  = 4'h2,
    SPCC_SHDR = 4'h6, SPCC_E1DR = 4'h7, SPCC_PDR  = 4'h5, SPCC_E2DR = 4'h4,
    SPCC_UDR  = 4'hC, SPCC_SIR  = 4'hD, SPCC_CIR  = 4'hF, SPCC_SHIR = 4'hE,
    SPCC_E1IR = 4'hA, SPCC_PIR  = 4'hB, SPCC_E2IR = 4'h9, SPCC_UIR  = 4'h8
  } spcc_tap_t;

  // protocol results
  typedef enum logic [2:0] {
    SPCC_R_NONE  = 3'h0, SPCC_R_RESET = 3'h1, SPCC_R_MATCH = 3'h2,
    SPCC_R_DISC  = 3'h3, SPCC_R_TSYNC = 3'h4, SPCC_R_NOMATCH = 3'h5,
    SPCC_R_HARD  = 3'h6
  } spcc_result_t;

  // connect status
  typedef enum logic [1:0] {
    SPCC_S_OFF = 2'h0, SPCC_S_ON = 2'h1, SPCC_S_RESET = 2'h2,
    SPCC_S_MCAST = 2'h3
  } spcc_status_t;

  // bit pair symbols: first bit, second bit
  localparam logic [1:0] SYM_IDLE = 2'h3;
  localparam logic [1:0] SYM_SEL  = 2'h0;
  localparam logic [1:0] SYM_ONE  = 2'h1;
  localparam logic [1:0] SYM_ZERO = 2'h2;
endpackage : spcc_pkg

// >>> logic/spcc_tap_mon.sv
// primary tap state mirror with asynchronous test reset
`timescale 1ns/100ps
module spcc_tap_mon
  import spcc_pkg::*;
(
  // link side
  input  wire logic      tck_i,
  input  wire logic      trst_n_i,
  input  wire logic      tms_i,
  // state out
  output spcc_tap_t      state_o
);
  spcc_tap_t next_state;

  // standard sixteen state transition graph
  always_comb begin
    unique case (state_o) // R3
      SPCC_TLR:  next_state = tms_i ? SPCC_TLR  : SPCC_RTI;
      SPCC_RTI:  next_state = tms_i ? SPCC_SDR  : SPCC_RTI;
      SPCC_SDR:  next_state = tms_i ? SPCC_SIR  : SPCC_CDR;
      SPCC_CDR:  next_state = tms_i ? SPCC_E1DR : SPCC_SHDR;
      SPCC_SHDR: next_state = tms_i ? SPCC_E1DR : SPCC_SHDR;
      SPCC_E1DR: next_state = tms_i ? SPCC_UDR  : SPCC_PDR;
      SPCC_PDR:  next_state = tms_i ? SPCC_E2DR : SPCC_PDR;
      SPCC_E2DR: next_state = tms_i ? SPCC_UDR  : SPCC_SHDR;
      SPCC_UDR:  next_state = tms_i ? SPCC_SDR  : SPCC_RTI;
      SPCC_SIR:  next_state = tms_i ? SPCC_TLR  : SPCC_CIR;
      SPCC_CIR:  next_state = tms_i ? SPCC_E1IR : SPCC_SHIR;
      SPCC_SHIR: next_state = tms_i ? SPCC_E1IR : SPCC_SHIR;
      SPCC_E1IR: next_state = tms_i ? SPCC_UIR  : SPCC_PIR;
      SPCC_PIR:  next_state = tms_i ? SPCC_E2IR : SPCC_PIR;
      SPCC_E2IR: next_state = tms_i ? SPCC_UIR  : SPCC_SHIR;
      SPCC_UIR:  next_state = tms_i ? SPCC_SDR  : SPCC_RTI;
    endcase
  end

  // advance on rising test clock, forced to reset asynchronously
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      state_o <= SPCC_TLR; // R5 R6
    end else begin
      state_o <= next_state; // R4
    end
  end

  // an asserted test reset puts the mirror in test logic reset
  property p_trst_tlr;
    @(posedge tck_i) !trst_n_i |-> state_o == SPCC_TLR;
  endproperty
  a_trst_tlr: assert property (p_trst_tlr) // R6
    else $error("mirror not in reset state under test reset");

  // five tms highs always reach test logic reset
  property p_five_ones;
    @(posedge tck_i) disable iff (!trst_n_i)
      tms_i [*5] |=> state_o == SPCC_TLR;
  endproperty
  a_five_ones: assert property (p_five_ones) // R3
    else $error("five tms highs did not reach reset state");

  // low tms in idle holds idle
  property p_idle_hold;
    @(posedge tck_i) disable iff (!trst_n_i)
      (state_o == SPCC_RTI && !tms_i) |=> state_o == SPCC_RTI;
  endproperty
  a_idle_hold: assert property (p_idle_hold) // R4
    else $error("idle not held with low tms");
endmodule : spcc_tap_mon

// >>> logic/spcc_sync.sv
// two flip-flop level synchroniser, one bit per lane
`timescale 1ns/100ps
module spcc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // lanes
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // two stage capture; first stage feeds only the second
  genvar g;
  for (g = 0; g < W; g++) begin : g_lane
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        meta[g] <= 1'b0;
        q_o[g]  <= 1'b0;
      end else begin
        meta[g] <= d_i[g];
        q_o[g]  <= meta[g];
      end
    end
  end
endmodule : spcc_sync

// >>> logic/spcc_connect.sv
// connect control: tap mirror, symbol framing and address decode
`timescale 1ns/100ps

// Overview of operation
// (R1) A select sequence closed with one to nine data pairs is a hard error and sets off status.
// (R2) Shadow sequences are taken only in reset, idle, pause-dr or pause-ir.
// (R3) A mirror machine follows the sixteen-state boundary-scan graph.
// (R4) The mirror steps on each rising test clock by the sampled mode select.
// (R5) The mirror starts in test logic reset.
// (R6) A low test reset forces the mirror to test logic reset at once.
// (R7) The sync global address is not recognised in reset or idle.
// (R8) In the pause states the sync global address is recognised.
// (R9) All select, capture, shift, exit and update states block sequences.
// (R10) Status comes from comparing the last valid address with board and global addresses.
// (R11) Address 000 gives reset, 3FE disconnect/off, 3FF sync/multicast.
// (R12) Board address equal gives match/on, any other gives no match/off.
// (R13) Symbols are bit pairs: 11 idle, 00 select, 01 one, 10 zero.
// (R14) A sequence is idle, select, ten data pairs lsb first, select, idle.
// (R15) On a match the same address is sent back at once with the same framing.
// (R16) The master holds mode select steady; a state change aborts the sequence.
// (R17) Decoding happens only after the closing select and idle pairs; a short close or an abort is reported as a hard error without the idle pair.
module spcc_connect
  import spcc_pkg::*;
(
  // system clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // primary link
  input  wire logic         primary_test_clock_i,
  input  wire logic         primary_test_reset_n_i,
  input  wire logic         primary_mode_select_i,
  input  wire logic         primary_serial_in_i,
  output logic              primary_serial_out_o,
  output logic              primary_serial_out_oe_o,
  // board address
  input  wire logic [9:0]   board_address_inputs_i,
  // results in system domain
  output spcc_result_t      result_o,
  output spcc_status_t      status_o,
  output logic [9:0]        last_address_o,
  output logic              result_valid_o,
  output spcc_tap_t         tap_state_o
);
  typedef enum logic [2:0] {
    SPCC_F_WAIT_I = 3'h0, SPCC_F_WAIT_S = 3'h1, SPCC_F_DATA = 3'h3,
    SPCC_F_END_I = 3'h2
  } spcc_frame_t;

  // ---- link domain ----
  spcc_tap_t   tap_state;
  spcc_tap_t   tap_prev;
  logic        half;
  logic        first_bit;
  spcc_frame_t frame;
  logic [9:0]  shreg;
  logic [3:0]  nbits;
  logic        all_one;
  logic        all_zero;
  logic [9:0]  cap_addr;
  logic [2:0]  cap_kind;
  logic        cap_tog;
  logic [4:0]  tx_idx;
  logic        tx_act;
  logic [9:0]  tx_addr;
  logic        ack_req;

  spcc_tap_mon u_mon (
    .tck_i    (primary_test_clock_i),
    .trst_n_i (primary_test_reset_n_i),
    .tms_i    (primary_mode_select_i),
    .state_o  (tap_state)
  );

  // stable states where sequences may run
  wire st_ok    = (tap_state == SPCC_TLR) || (tap_state == SPCC_RTI)
               || (tap_state == SPCC_PDR) || (tap_state == SPCC_PIR); // R2 R9
  wire st_pause = (tap_state == SPCC_PDR) || (tap_state == SPCC_PIR);
  wire st_chg   = tap_state != tap_prev; // R16
  wire [1:0] sym = {first_bit, primary_serial_in_i}; // R13
  wire sym_stb  = half && st_ok && !st_chg;
  wire is_one   = sym == SYM_ONE;
  wire is_data  = is_one || sym == SYM_ZERO;
  wire [9:0] new_sh = {is_one, shreg[9:1]}; // R14 lsb first
  wire abort_hard = (frame == SPCC_F_DATA) && nbits != CNT_ZERO
                 && (!st_ok || st_chg);

  // kind codes for the crossing: 0 ok, 1 hard, 2 all ones long, 3 zeros long
  wire seq_done = sym_stb && frame == SPCC_F_END_I && sym == SYM_IDLE; // R17
  wire seq_bad  = sym_stb && frame == SPCC_F_END_I && sym != SYM_IDLE
               && sym != SYM_SEL;
  wire short_close = sym_stb && frame == SPCC_F_DATA && sym == SYM_SEL
                  && nbits != CNT_ZERO && nbits < CNT_FULL; // R1
  wire long_seen = nbits > CNT_FULL;
  // board match on a full close; registered so the falling edge sees it
  wire ack_hit = seq_done && nbits == CNT_FULL
              && shreg == board_address_inputs_i
              && shreg != RESET_ADDR && shreg != DISC_ADDR
              && shreg != TSYNC_ADDR; // R15

  // receiver framing on rising test clock
  always_ff @(posedge primary_test_clock_i or negedge primary_test_reset_n_i)
  begin
    if (!primary_test_reset_n_i) begin
      tap_prev  <= SPCC_TLR;
      half      <= 1'b0;
      first_bit <= 1'b1;
      frame     <= SPCC_F_WAIT_I;
      shreg     <= RESET_ADDR;
      nbits     <= CNT_ZERO;
      all_one   <= 1'b1;
      all_zero  <= 1'b1;
      cap_addr  <= RESET_ADDR;
      cap_kind  <= 3'h0;
      cap_tog   <= 1'b0;
      ack_req   <= 1'b0;
    end else begin
      tap_prev  <= tap_state;
      ack_req   <= ack_hit; // R15
      first_bit <= primary_serial_in_i;
      // first edge inside a new stable state opens a pair
      half      <= (st_ok && !tx_act) ? (st_chg || !half) : 1'b0;
      if (abort_hard || short_close) begin
        cap_kind <= 3'h1; // R1
        cap_tog  <= !cap_tog;
        frame    <= SPCC_F_WAIT_I;
      end else if (!st_ok || st_chg || tx_act) begin
        frame <= SPCC_F_WAIT_I; // R16 R9
      end else if (sym_stb) begin
        unique case (frame)
          SPCC_F_WAIT_I: if (sym == SYM_IDLE) frame <= SPCC_F_WAIT_S;
          SPCC_F_WAIT_S: begin
            nbits    <= CNT_ZERO;
            all_one  <= 1'b1;
            all_zero <= 1'b1;
            frame    <= (sym == SYM_SEL) ? SPCC_F_DATA
                      : (sym == SYM_IDLE) ? SPCC_F_WAIT_S : SPCC_F_WAIT_I;
          end
          SPCC_F_DATA: begin
            if (is_data) begin
              shreg    <= new_sh;
              nbits    <= long_seen ? nbits : nbits + CNT_ONE;
              all_one  <= all_one && is_one;
              all_zero <= all_zero && !is_one;
            end else if (sym == SYM_SEL && nbits != CNT_ZERO) begin
              frame <= SPCC_F_END_I;
            end else begin
              frame <= SPCC_F_WAIT_I; // soft error
            end
          end
          SPCC_F_END_I: begin
            if (seq_done) begin
              cap_addr <= shreg;
              cap_kind <= (nbits == CNT_FULL) ? 3'h0
                        : all_one ? 3'h2 : all_zero ? 3'h3 : 3'h1;
              cap_tog  <= !cap_tog; // R17
            end else if (seq_bad) begin
              cap_kind <= 3'h1;
              cap_tog  <= !cap_tog;
            end
            frame <= (sym == SYM_SEL) ? SPCC_F_END_I : SPCC_F_WAIT_I;
          end
          default: frame <= SPCC_F_WAIT_I;
        endcase
      end
    end
  end

  // acknowledge transmit: 28 bits, framed like the select sequence
  wire [4:0] pair_i = tx_idx >> 1;
  wire       tx_hi  = !tx_idx[0];
  wire [3:0] dbit_i = 4'(pair_i - 5'h02);
  wire       dval   = tx_addr[dbit_i];
  wire       tx_bit = (pair_i == 5'h00 || pair_i == 5'h0D) ? 1'b1
                    : (pair_i == 5'h01 || pair_i == 5'h0C) ? 1'b0
                    : (tx_hi ? !dval : dval);

  // serial out changes on falling test clock
  always_ff @(negedge primary_test_clock_i or negedge primary_test_reset_n_i)
  begin
    if (!primary_test_reset_n_i) begin
      tx_act  <= 1'b0;
      tx_idx  <= 5'h00;
      tx_addr <= RESET_ADDR;
      primary_serial_out_o    <= 1'b1;
      primary_serial_out_oe_o <= 1'b0;
    end else if (ack_req && !tx_act) begin
      tx_act  <= 1'b1;
      tx_idx  <= 5'h01;
      tx_addr <= shreg;
      primary_serial_out_o    <= 1'b1;
      primary_serial_out_oe_o <= 1'b1;
    end else if (tx_act) begin
      tx_idx <= tx_idx + 5'h01;
      // enable drops on the falling edge that ends the last idle bit
      if (tx_idx == TX_END) begin
        tx_act <= 1'b0;
        primary_serial_out_o    <= 1'b1;
        primary_serial_out_oe_o <= 1'b0;
      end else begin
        primary_serial_out_o <= tx_bit;
      end
    end
  end

  // ---- system domain ----
  logic [2:0] tog_s;
  logic       tog_d;
  logic [4:0] st_s;

  spcc_sync #(.W(3)) u_tog (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    ({cap_tog, st_pause, 1'b0}),
    .q_o    (tog_s)
  );
  spcc_sync #(.W(5)) u_st (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    ({1'b0, tap_state}),
    .q_o    (st_s)
  );

  // decode of the captured address once the event arrives
  wire          ev      = tog_s[2] ^ tog_d;
  wire          pause_s = tog_s[1];
  wire [9:0]    a       = cap_addr;
  wire          k_hard  = cap_kind == 3'h1;
  wire          k_ones  = cap_kind == 3'h2;
  wire          k_zeros = cap_kind == 3'h3;
  spcc_result_t next_result;
  spcc_status_t next_status;

  always_comb begin
    next_result = SPCC_R_NOMATCH; // R12
    next_status = SPCC_S_OFF;
    if (k_hard) begin
      next_result = SPCC_R_HARD; // R1
    end else if (k_zeros || a == RESET_ADDR) begin
      next_result = SPCC_R_RESET; // R11
      next_status = SPCC_S_RESET;
    end else if ((k_ones || a == TSYNC_ADDR) && pause_s) begin
      next_result = SPCC_R_TSYNC; // R8 R11
      next_status = SPCC_S_MCAST;
    end else if (k_ones || a == TSYNC_ADDR || a == DISC_ADDR) begin
      next_result = SPCC_R_DISC; // R7 R11
    end else if (a == board_address_inputs_i) begin
      next_result = SPCC_R_MATCH; // R10 R12
      next_status = SPCC_S_ON;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tog_d          <= 1'b0;
      result_o       <= SPCC_R_NONE;
      status_o       <= SPCC_S_OFF;
      last_address_o <= RESET_ADDR;
      result_valid_o <= 1'b0;
      tap_state_o    <= SPCC_TLR;
    end else begin
      tog_d          <= tog_s[2];
      result_valid_o <= ev;
      tap_state_o    <= spcc_tap_t'(st_s[3:0]);
      if (ev) begin
        result_o       <= next_result;
        status_o       <= next_status;
        last_address_o <= a;
      end
    end
  end

  // a hard error always leaves the port off
  property p_hard_off;
    @(posedge clk_i) disable iff (srst_i)
      (ev && k_hard) |=> (status_o == SPCC_S_OFF && result_o == SPCC_R_HARD);
  endproperty
  a_hard_off: assert property (p_hard_off) // R1
    else $error("hard error did not give off status");

  // receiver falls back to waiting for idle when the mirror is outside stable states
  property p_no_rx;
    @(posedge primary_test_clock_i) disable iff (!primary_test_reset_n_i)
      !st_ok |=> frame == SPCC_F_WAIT_I;
  endproperty
  a_no_rx: assert property (p_no_rx) // R2
    else $error("receiver active outside stable states");

  // sync address outside pause never gives multicast
  property p_no_tsync;
    @(posedge clk_i) disable iff (srst_i)
      (ev && !pause_s) |=> status_o != SPCC_S_MCAST;
  endproperty
  a_no_tsync: assert property (p_no_tsync) // R7
    else $error("multicast outside pause");

  // reset address gives reset status
  property p_reset_addr;
    @(posedge clk_i) disable iff (srst_i)
      (ev && !k_hard && a == RESET_ADDR) |=> status_o == SPCC_S_RESET;
  endproperty
  a_reset_addr: assert property (p_reset_addr) // R11
    else $error("reset address not decoded");

  // disconnect address gives the disconnect result
  property p_disc;
    @(posedge clk_i) disable iff (srst_i)
      (ev && !k_hard && a == DISC_ADDR) |=> result_o == SPCC_R_DISC;
  endproperty
  a_disc: assert property (p_disc) // R11
    else $error("disconnect address not decoded");

  // board match gives on, one cycle after the event
  sequence s_match_ev;
    ev && cap_kind == 3'h0 && a == board_address_inputs_i
      && a != RESET_ADDR && a != DISC_ADDR && a != TSYNC_ADDR;
  endsequence
  property p_match;
    @(posedge clk_i) disable iff (srst_i)
      s_match_ev |=> status_o == SPCC_S_ON ##0 result_valid_o;
  endproperty
  a_match: assert property (p_match) // R12
    else $error("matching address not on");

  // acknowledge starts with output enable, held for the next eight falling edges
  property p_ack;
    @(negedge primary_test_clock_i) disable iff (!primary_test_reset_n_i)
      (ack_req && !tx_act) |=> primary_serial_out_oe_o [*8];
  endproperty
  a_ack: assert property (p_ack) // R15
    else $error("acknowledge not driven");

  // a state change drops any partial frame
  property p_abort;
    @(posedge primary_test_clock_i) disable iff (!primary_test_reset_n_i)
      st_chg |=> frame == SPCC_F_WAIT_I;
  endproperty
  a_abort: assert property (p_abort) // R16
    else $error("frame not aborted on state change");
endmodule : spcc_connect

// >>> dv/spcc_master.sv
// bus master model driving the primary scan link
`timescale 1ns/100ps
module spcc_master
  import spcc_pkg::*;
(
  // primary link drive
  output logic tck_o,
  output logic trst_n_o,
  output logic tms_o,
  output logic tdi_o
);
  logic hold_tms;

  // idle levels, data line pulled high
  initial begin
    tck_o    = 1'b0;
    trst_n_o = 1'b0;
    tms_o    = 1'b1;
    tdi_o    = 1'b1;
    hold_tms = 1'b1;
  end

  // one link cycle, link clock stands still between calls
  task automatic step(input logic m, input logic d);
    tms_o    = m;
    tdi_o    = d;
    hold_tms = m;
    #80.7 tck_o = 1'b1;
    #79.3 tck_o = 1'b0;
  endtask : step

  // test reset level
  task automatic set_rst(input logic n);
    trst_n_o = n;
  endtask : set_rst

  // one bit pair, mode select held steady
  task automatic pair(input logic [1:0] sym);
    step(hold_tms, sym[1]);
    step(hold_tms, sym[0]);
  endtask : pair

  // select frame with n data pairs, then idle through the acknowledge
  task automatic frame(input logic [9:0] a, input int n);
    pair(SYM_IDLE);
    pair(SYM_SEL);
    for (int i = 0; i < n; i++) begin
      pair(a[i] ? SYM_ONE : SYM_ZERO);
    end
    pair(SYM_SEL);
    pair(SYM_IDLE);
    repeat (30) step(hold_tms, 1'b1);
  endtask : frame
endmodule : spcc_master

// >>> dv/testbench.sv
// self-checking bench for the scan port connect control
`timescale 1ns/100ps
module testbench
  import spcc_pkg::*;
;
  logic         clk;
  logic         srst;
  logic [9:0]   board;
  wire          tck;
  wire          trst_n;
  wire          tms;
  wire          tdi;
  logic         sout;
  logic         soe;
  spcc_result_t result;
  spcc_status_t status;
  logic [9:0]   last_addr;
  logic         rvalid;
  spcc_tap_t    tap;
  spcc_result_t got_res;
  spcc_status_t got_st;
  spcc_tap_t    exp_tap;
  logic [31:0]  ack;
  logic [31:0]  seed;
  logic [31:0]  r32;
  int           mismatches;
  int           checks_done;
  int           nvalid;
  int           ackn;

  spcc_connect spcc_connect_inst (
    .clk_i                   (clk),
    .srst_i                  (srst),
    .primary_test_clock_i    (tck),
    .primary_test_reset_n_i  (trst_n),
    .primary_mode_select_i   (tms),
    .primary_serial_in_i     (tdi),
    .primary_serial_out_o    (sout),
    .primary_serial_out_oe_o (soe),
    .board_address_inputs_i  (board),
    .result_o                (result),
    .status_o                (status),
    .last_address_o          (last_addr),
    .result_valid_o          (rvalid),
    .tap_state_o             (tap)
  );

  spcc_master spcc_master_inst (
    .tck_o    (tck),
    .trst_n_o (trst_n),
    .tms_o    (tms),
    .tdi_o    (tdi)
  );

  // system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // result capture and acknowledge shift-in
  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      got_res <= result;
      got_st  <= status;
      nvalid  <= nvalid + 1;
    end
  end
  always @(posedge tck) begin
    if (soe === 1'b1) begin
      ack  <= {ack[30:0], sout};
      ackn <= ackn + 1;
    end
  end

  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // expected mirror step
  function automatic spcc_tap_t next_tap(spcc_tap_t s, logic m);
    case (s)
      SPCC_TLR:                    return m ? SPCC_TLR  : SPCC_RTI;
      SPCC_RTI, SPCC_UDR, SPCC_UIR: return m ? SPCC_SDR  : SPCC_RTI;
      SPCC_SDR:                    return m ? SPCC_SIR  : SPCC_CDR;
      SPCC_SIR:                    return m ? SPCC_TLR  : SPCC_CIR;
      SPCC_CDR, SPCC_SHDR:         return m ? SPCC_E1DR : SPCC_SHDR;
      SPCC_E1DR:                   return m ? SPCC_UDR  : SPCC_PDR;
      SPCC_PDR:                    return m ? SPCC_E2DR : SPCC_PDR;
      SPCC_E2DR:                   return m ? SPCC_UDR  : SPCC_SHDR;
      SPCC_CIR, SPCC_SHIR:         return m ? SPCC_E1IR : SPCC_SHIR;
      SPCC_E1IR:                   return m ? SPCC_UIR  : SPCC_PIR;
      SPCC_PIR:                    return m ? SPCC_E2IR : SPCC_PIR;
      SPCC_E2IR:                   return m ? SPCC_UIR  : SPCC_SHIR;
      default:                     return SPCC_TLR;
    endcase
  endfunction : next_tap

  // expected decode of a complete frame
  function automatic spcc_result_t exp_res(logic [9:0] a, logic [9:0] b,
                                           spcc_tap_t s);
    if (a == RESET_ADDR) return SPCC_R_RESET;
    if (a == DISC_ADDR) return SPCC_R_DISC;
    if (a == TSYNC_ADDR)
      return (s == SPCC_PDR || s == SPCC_PIR) ? SPCC_R_TSYNC : SPCC_R_DISC;
    if (a == b) return SPCC_R_MATCH;
    return SPCC_R_NOMATCH;
  endfunction : exp_res

  // status that goes with a result
  function automatic spcc_status_t st_of(spcc_result_t r);
    case (r)
      SPCC_R_RESET: return SPCC_S_RESET;
      SPCC_R_MATCH: return SPCC_S_ON;
      SPCC_R_TSYNC: return SPCC_S_MCAST;
      default:      return SPCC_S_OFF;
    endcase
  endfunction : st_of

  // acknowledge bits in wire order
  function automatic logic [27:0] ack_pat(logic [9:0] a);
    logic [27:0] p;
    p = {24'h000000, SYM_IDLE, SYM_SEL};
    for (int i = 0; i < 10; i++) p = {p[25:0], a[i] ? SYM_ONE : SYM_ZERO};
    return {p[23:0], SYM_SEL, SYM_IDLE};
  endfunction : ack_pat

  // compare and count
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one mirror step with state check
  task automatic mv(input logic m);
    spcc_master_inst.step(m, 1'b1);
    exp_tap = next_tap(exp_tap, m);
    chk("tap", 32'(tap), 32'(exp_tap));
  endtask : mv

  // walk n mode bits, first bit in bit 0
  task automatic path(input logic [7:0] bits, input int n);
    for (int i = 0; i < n; i++) mv(bits[i]);
  endtask : path

  // send one frame and check its outcome
  task automatic shoot(input logic [9:0] a, input int n);
    int           nv0;
    logic         ok;
    logic         hit;
    spcc_result_t r;
    nv0  = nvalid;
    ackn = 0;
    ok   = exp_tap inside {SPCC_TLR, SPCC_RTI, SPCC_PDR, SPCC_PIR};
    r    = (n < 10) ? SPCC_R_HARD : exp_res(a, board, exp_tap);
    hit  = ok && (r == SPCC_R_MATCH);
    spcc_master_inst.frame(a, n);
    repeat (8) @(posedge clk);
    chk("valid", 32'(nvalid - nv0), ok ? 32'h1 : 32'h0);
    if (ok) begin
      chk("result", 32'(got_res), 32'(r));
      chk("status", 32'(got_st), 32'(st_of(r)));
    end
    chk("ack_len", 32'(ackn), hit ? 32'd28 : 32'd0);
    if (hit) begin
      chk("ack", 32'(ack[27:0]), 32'(ack_pat(a)));
      chk("last_addr", 32'(last_addr), 32'(a));
    end
  endtask : shoot

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // hang guard
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end

  // main sequence
  initial begin
    srst  = 1'b1;
    board = 10'h000;
    seed  = 32'hDF91;
    repeat (12) @(posedge clk);
    srst  <= 1'b0;
    board <= 10'(rnd() % 1000) + 10'h005;
    @(posedge clk);
    chk("status_rst", 32'(status), 32'(SPCC_S_OFF));
    chk("tap_pwr", 32'(tap), 32'(SPCC_TLR));
    spcc_master_inst.set_rst(1'b1);
    exp_tap = SPCC_TLR;
    path(8'h03, 2);
    shoot(board, 10);
    mv(1'b0);
    shoot(RESET_ADDR, 10);
    shoot(DISC_ADDR, 10);
    shoot(TSYNC_ADDR, 10);
    shoot(board ^ 10'h001, 10);
    for (int k = 0; k < 3; k++) shoot(10'(rnd()), 10);
    shoot(board, 9);
    shoot(board, 1);
    path(8'h05, 4);
    shoot(TSYNC_ADDR, 10);
    shoot(board, 10);
    path(8'h03, 3);
    path(8'h0B, 5);
    shoot(TSYNC_ADDR, 10);
    path(8'h03, 3);
    path(8'h01, 3);
    shoot(board, 10);
    // test reset with the link clock stopped
    spcc_master_inst.set_rst(1'b0);
    repeat (6) @(posedge clk);
    chk("tap_trst", 32'(tap), 32'(SPCC_TLR));
    spcc_master_inst.set_rst(1'b1);
    exp_tap = SPCC_TLR;
    path(8'h03, 2);
    for (int k = 0; k < 40; k++) begin
      r32 = rnd();
      mv(r32[0]);
    end
    wrap_up();
  end
endmodule : testbench
